// [hw/fpb_pkg.sv]
// shared constants, types and address helpers of the page buffer commands
package fpb_pkg;

  localparam logic [7:0] OP_XFR_B1 = 8'h53;
  localparam logic [7:0] OP_XFR_B2 = 8'h55;
  localparam logic [7:0] OP_CMP_B1 = 8'h60;
  localparam logic [7:0] OP_CMP_B2 = 8'h61;
  localparam logic [7:0] OP_RWR_B1 = 8'h58;
  localparam logic [7:0] OP_RWR_B2 = 8'h59;
  localparam logic [7:0] OP_STATUS = 8'hD7;

  // frame lengths in bits
  localparam logic [5:0] OP_BITS   = 6'h08;
  localparam logic [5:0] CMD_BITS  = 6'h20;
  localparam logic [5:0] DATA_BITS = 6'h28;

  // status byte one layout
  localparam int ST_RDY   = 7;
  localparam int ST_COMP  = 6;
  localparam int ST_DEN   = 2;
  localparam int ST_PROT  = 1;
  localparam int ST_PSIZE = 0;
  // status byte two bits kept here
  localparam int ST2_PS2  = 2;
  localparam int ST2_PS1  = 1;
  // value is arbitrary
  localparam logic [3:0] DENSITY_CODE = 4'h5;
  localparam logic       COMP_RESET   = 1'b0;

  // timing
  localparam int CLK_NS               = 40;
  localparam int PAGE_COPY_TIME_NS    = 100000;
  localparam int PAGE_CHECK_TIME_NS   = 100000;
  localparam int REWRITE_TIME_NS      = 2000000;
  localparam int PAGE_COPY_CYC        = PAGE_COPY_TIME_NS / CLK_NS;
  localparam int PAGE_CHECK_CYC       = PAGE_CHECK_TIME_NS / CLK_NS;
  localparam int REWRITE_CYC          = REWRITE_TIME_NS / CLK_NS;
  localparam int TMR_W                = 20;
  localparam int SCK_HALF             = 4;
  localparam int PE_LIMIT             = 50000;

  typedef enum logic [1:0] {FPB_XFR, FPB_CMP, FPB_RWR, FPB_RMW} fpb_op_t;

  // page index from the three address bytes
  function automatic logic [11:0] page_of(input logic [23:0] a,
                                          input logic        bin);
    page_of = bin ? a[19:8] : a[20:9];
  endfunction

  // three address bytes from a page index
  function automatic logic [23:0] addr_of(input logic [11:0] p,
                                          input logic        bin);
    addr_of = bin ? {4'h0, p, 8'h00} : {3'h0, p, 9'h000};
  endfunction

endpackage

// [hw/fpb_link_if.sv]
// serial link between host master and flash device
`timescale 1ns/1ps
interface fpb_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // released line reads high
  assign so_line = so_oe ? so : 1'b1;

  modport host (output cs_n, output sck, output si, input so_line);
  modport device (input cs_n, input sck, input si,
                  output so, output so_oe);
endinterface

// [hw/fpb_device.sv]
// flash device end: command decode, self-timed ops, status read
// Summary of operation
// - 53h/55h plus address: page to buffer
// - 264 geometry: 3 dummy, 12 page, 9 dummy
// - 256 geometry: 4 dummy, 12 page, 8 dummy
// - command clocked under cs, starts at cs rise
// - busy during transfer, ready afterwards
// - 60h/61h plus address: page to buffer compare
// - compare at cs rise, busy, result bit 6
// - compare bit 0 equal, 1 differs
// - 58h/59h plus address: auto page rewrite
// - rewrite copies then programs back, busy throughout
// - data after rewrite address means read-modify-write
// - host refreshes sector within 50,000 operations
// - d7h starts status shifting out on so
// - status repeats after two bytes while clocked
// - status readable at any time, even busy
// - ready flag in both bytes, refreshed each byte
// - cs rise ends status read, so floats
// - status bit 7: 0 busy, 1 ready
// - bit 1 protection, bits 5:2 capacity code
// - bit 0 page geometry; all bits read-only
// - suspended buffer ignores commands altering it
// - host polls status until ready rises
`timescale 1ns/1ps
module fpb_device #(
  parameter int REWRITE_CYC = fpb_pkg::REWRITE_CYC
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            ce,
  fpb_link_if.device           link,
  input  wire logic            binary_page,
  input  wire logic            protect_en,
  input  wire logic            first_buffer_suspend_flag,
  input  wire logic            second_buffer_suspend_flag,
  input  wire logic            cmp_mismatch,
  output logic                 op_start,
  output fpb_pkg::fpb_op_t     op_kind,
  output logic                 op_buf,
  output logic [11:0]          op_page,
  output logic                 op_done,
  output logic                 busy
);

  typedef enum logic {FPB_IDLE, FPB_RUN} fpb_state_t;

  // ---------------- link side, sck domain ----------------
  logic [5:0]  cnt_r;
  logic [31:0] sr_r;
  logic        stat_r;
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  logic        len_ok_r;
  logic        ext_r;
  logic [31:0] sr_nxt;

  assign sr_nxt = {sr_r[30:0], link.si};

  // frame bit counter, cleared by cs high
  always_ff @(posedge link.sck or negedge rstn or posedge link.cs_n)
  begin
    if (!rstn || link.cs_n)
    begin
      cnt_r  <= 6'h00;
      stat_r <= 1'b0;
    end
    else
    begin
      // si taken on rising edge
      if (cnt_r != 6'h3F)
        cnt_r <= cnt_r + 6'h01;
      if (cnt_r == fpb_pkg::OP_BITS - 6'h01 &&
          sr_nxt[7:0] == fpb_pkg::OP_STATUS)
        stat_r <= 1'b1;
    end
  end

  // command capture, held after cs rises for the clk side
  always_ff @(posedge link.sck or negedge rstn)
  begin
    if (!rstn)
    begin
      sr_r     <= 32'h0000_0000;
      op_r     <= 8'h00;
      addr_r   <= 24'h00_0000;
      len_ok_r <= 1'b0;
      ext_r    <= 1'b0;
    end
    else if (!link.cs_n)
    begin
      sr_r     <= sr_nxt;
      len_ok_r <= (cnt_r == fpb_pkg::CMD_BITS - 6'h01);
      if (cnt_r == fpb_pkg::CMD_BITS - 6'h01)
      begin
        op_r   <= sr_nxt[31:24];
        addr_r <= sr_nxt[23:0];
      end
      if (cnt_r == 6'h00)
        ext_r <= 1'b0;
      else if (cnt_r == fpb_pkg::DATA_BITS - 6'h01)
        ext_r <= 1'b1;
    end
  end

  // status levels into sck domain, three stages
  logic [9:0] sy1_r;
  logic [9:0] sy2_r;
  logic [9:0] sy3_r;
  logic [9:0] sv_r;
  logic [9:0] st_src_r;

  always_ff @(negedge link.sck or negedge rstn)
  begin
    if (!rstn)
    begin
      sy1_r <= 10'h000;
      sy2_r <= 10'h000;
      sy3_r <= 10'h000;
      sv_r  <= 10'h000;
    end
    else
    begin
      sy1_r <= st_src_r;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      if (sy2_r == sy3_r)
        sv_r <= sy3_r;
    end
  end

  // status shifter on falling edge
  logic [3:0] idx_r;
  logic [7:0] sh_r;
  logic [7:0] byte1;
  logic [7:0] byte2;

  always_comb
  begin
    byte1 = 8'h00;
    byte1[fpb_pkg::ST_RDY]   = sv_r[0];
    byte1[fpb_pkg::ST_COMP]  = sv_r[1];
    byte1[fpb_pkg::ST_DEN +: 4] = fpb_pkg::DENSITY_CODE;
    byte1[fpb_pkg::ST_PROT]  = sv_r[2];
    byte1[fpb_pkg::ST_PSIZE] = sv_r[3];
    byte2 = 8'h00;
    byte2[fpb_pkg::ST_RDY]   = sv_r[0];
    byte2[fpb_pkg::ST2_PS2]  = sv_r[5];
    byte2[fpb_pkg::ST2_PS1]  = sv_r[4];
  end

  always_ff @(negedge link.sck or negedge rstn or posedge link.cs_n)
  begin
    if (!rstn || link.cs_n)
    begin
      idx_r      <= 4'h0;
      sh_r       <= 8'h00;
      link.so    <= 1'b0;
      link.so_oe <= 1'b0;
    end
    else if (stat_r)
    begin
      link.so_oe <= 1'b1;
      idx_r      <= idx_r + 4'h1;
      // fresh byte snapshot each byte
      if (idx_r[2:0] == 3'h0)
      begin
        link.so <= idx_r[3] ? byte2[7] : byte1[7];
        sh_r    <= idx_r[3] ? {byte2[6:0], 1'b0}
                            : {byte1[6:0], 1'b0};
      end
      else
      begin
        link.so <= sh_r[7];
        sh_r    <= {sh_r[6:0], 1'b0};
      end
    end
  end

  // ---------------- core side, clk domain ----------------
  logic cs1_r;
  logic cs2_r;
  logic cs3_r;
  logic csv_r;
  logic cs_rise;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs1_r <= 1'b1;
      cs2_r <= 1'b1;
      cs3_r <= 1'b1;
      csv_r <= 1'b1;
    end
    else if (ce)
    begin
      cs1_r <= link.cs_n;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      if (cs2_r == cs3_r)
        csv_r <= cs3_r;
    end
  end

  assign cs_rise = ce && !csv_r && cs2_r && cs3_r;

  // decode of the captured frame
  logic          dec_ok;
  logic          dec_buf;
  fpb_pkg::fpb_op_t dec_kind;
  logic          buf_susp;

  always_comb
  begin
    dec_ok   = 1'b0;
    dec_buf  = 1'b0;
    dec_kind = fpb_pkg::FPB_XFR;
    case (op_r)
      fpb_pkg::OP_XFR_B1, fpb_pkg::OP_XFR_B2:
      begin
        dec_ok   = len_ok_r;
        dec_buf  = (op_r == fpb_pkg::OP_XFR_B2);
        dec_kind = fpb_pkg::FPB_XFR;
      end
      fpb_pkg::OP_CMP_B1, fpb_pkg::OP_CMP_B2:
      begin
        dec_ok   = len_ok_r;
        dec_buf  = (op_r == fpb_pkg::OP_CMP_B2);
        dec_kind = fpb_pkg::FPB_CMP;
      end
      fpb_pkg::OP_RWR_B1, fpb_pkg::OP_RWR_B2:
      begin
        dec_ok   = len_ok_r || ext_r;
        dec_buf  = (op_r == fpb_pkg::OP_RWR_B2);
        dec_kind = ext_r ? fpb_pkg::FPB_RMW
                         : fpb_pkg::FPB_RWR;
      end
      default:
      begin
        dec_ok = 1'b0;
      end
    endcase
  end

  assign buf_susp = dec_buf ? second_buffer_suspend_flag
                            : first_buffer_suspend_flag;

  fpb_state_t              state_r;
  logic [fpb_pkg::TMR_W-1:0] tmr_r;
  logic                    comp_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r  <= FPB_IDLE;
      tmr_r    <= '0;
      op_start <= 1'b0;
      op_done  <= 1'b0;
      op_kind  <= fpb_pkg::FPB_XFR;
      op_buf   <= 1'b0;
      op_page  <= 12'h000;
      busy     <= 1'b0;
    end
    else if (ce)
    begin
      op_start <= 1'b0;
      op_done  <= 1'b0;
      case (state_r)
        FPB_IDLE:
        begin
          // compare leaves the buffer intact
          if (cs_rise && dec_ok &&
              (dec_kind == fpb_pkg::FPB_CMP || !buf_susp))
          begin
            state_r  <= FPB_RUN;
            busy     <= 1'b1;
            op_start <= 1'b1;
            op_kind  <= dec_kind;
            op_buf   <= dec_buf;
            op_page  <= fpb_pkg::page_of(addr_r, binary_page);
            case (dec_kind)
              fpb_pkg::FPB_XFR:
                tmr_r <= fpb_pkg::TMR_W'(fpb_pkg::PAGE_COPY_CYC - 1);
              fpb_pkg::FPB_CMP:
                tmr_r <= fpb_pkg::TMR_W'(fpb_pkg::PAGE_CHECK_CYC - 1);
              default:
                tmr_r <= fpb_pkg::TMR_W'(REWRITE_CYC - 1);
            endcase
          end
        end
        FPB_RUN:
        begin
          if (tmr_r == '0)
          begin
            state_r <= FPB_IDLE;
            busy    <= 1'b0;
            op_done <= 1'b1;
          end
          else
            tmr_r <= tmr_r - 1'b1;
        end
        default:
          state_r <= FPB_IDLE;
      endcase
    end
  end

  // compare outcome latched at completion
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      comp_r <= fpb_pkg::COMP_RESET;
    else if (ce && state_r == FPB_RUN && tmr_r == '0 &&
             op_kind == fpb_pkg::FPB_CMP)
      comp_r <= cmp_mismatch;
  end

  // status source levels for the link side
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_src_r <= 10'h000;
    else if (ce)
      st_src_r <= {4'h0, second_buffer_suspend_flag,
                   first_buffer_suspend_flag, binary_page,
                   protect_en, comp_r, state_r == FPB_IDLE};
  end

endmodule

// [hw/fpb_host.sv]
// host master end: frames commands, reads status, polls ready
`timescale 1ns/1ps
module fpb_host (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  fpb_link_if.host         link,
  input  wire logic        req,
  input  wire logic [7:0]  req_op,
  input  wire logic [11:0] req_page,
  input  wire logic        req_binary,
  input  wire logic        req_addr_en,
  input  wire logic [2:0]  req_rd_bytes,
  input  wire logic        req_poll,
  input  wire logic        req_pe,
  input  wire logic        refresh_ack,
  output logic             busy,
  output logic             rsp_valid,
  output logic [7:0]       rsp_byte,
  output logic             refresh_due
);

  typedef enum logic [1:0] {FPH_IDLE, FPH_SHIFT, FPH_END} fph_state_t;

  // so pin through three stages
  logic so1_r;
  logic so2_r;
  logic so3_r;
  logic sov_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      so1_r <= 1'b1;
      so2_r <= 1'b1;
      so3_r <= 1'b1;
      sov_r <= 1'b1;
    end
    else if (ce)
    begin
      so1_r <= link.so_line;
      so2_r <= so1_r;
      so3_r <= so2_r;
      if (so2_r == so3_r)
        sov_r <= so3_r;
    end
  end

  fph_state_t  state_r;
  logic [2:0]  div_r;
  logic [31:0] tx_r;
  logic [5:0]  tx_left_r;
  logic [2:0]  rx_left_r;
  logic [2:0]  rxb_r;
  logic [7:0]  rx_r;
  logic        poll_r;
  logic        fin_r;
  logic        rx_go_r;
  logic [7:0]  rx_nxt;
  logic        half_done;

  assign rx_nxt    = {rx_r[6:0], sov_r};
  assign half_done = (div_r == 3'(fpb_pkg::SCK_HALF - 1));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r   <= FPH_IDLE;
      div_r     <= 3'h0;
      tx_r      <= 32'h0000_0000;
      tx_left_r <= 6'h00;
      rx_left_r <= 3'h0;
      rxb_r     <= 3'h0;
      rx_r      <= 8'h00;
      poll_r    <= 1'b0;
      fin_r     <= 1'b0;
      rx_go_r   <= 1'b0;
      busy      <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte  <= 8'h00;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.si   <= 1'b0;
    end
    else if (ce)
    begin
      rsp_valid <= 1'b0;
      case (state_r)
        FPH_IDLE:
        begin
          if (req)
          begin
            state_r   <= FPH_SHIFT;
            busy      <= 1'b1;
            div_r     <= 3'h0;
            link.cs_n <= 1'b0;
            // opcode then address bytes
            tx_r      <= {req_op,
                          fpb_pkg::addr_of(req_page, req_binary)};
            link.si   <= req_op[7];
            tx_left_r <= req_addr_en ? fpb_pkg::CMD_BITS
                                     : fpb_pkg::OP_BITS;
            rx_left_r <= req_rd_bytes;
            rxb_r     <= 3'h0;
            poll_r    <= req_poll;
            fin_r     <= 1'b0;
            rx_go_r   <= 1'b0;
          end
        end
        FPH_SHIFT:
        begin
          div_r <= half_done ? 3'h0 : div_r + 3'h1;
          if (half_done && !link.sck)
          begin
            link.sck <= 1'b1;
            if (tx_left_r != 6'h00)
              tx_left_r <= tx_left_r - 6'h01;
            else
              rx_go_r <= 1'b1;
          end
          else if (half_done && link.sck)
          begin
            link.sck <= 1'b0;
            // synced so bit settled well before this fall
            if (rx_go_r)
            begin
              rx_r  <= rx_nxt;
              rxb_r <= rxb_r + 3'h1;
              if (rxb_r == 3'h7)
              begin
                rsp_valid <= 1'b1;
                rsp_byte  <= rx_nxt;
                if (poll_r)
                  fin_r <= rx_nxt[fpb_pkg::ST_RDY];
                else
                begin
                  rx_left_r <= rx_left_r - 3'h1;
                  fin_r     <= (rx_left_r == 3'h1);
                end
              end
            end
            if (fin_r || (tx_left_r == 6'h00 && rx_left_r == 3'h0 &&
                          !poll_r))
            begin
              state_r <= FPH_END;
            end
            else
            begin
              tx_r    <= {tx_r[30:0], 1'b0};
              link.si <= tx_r[30];
            end
          end
        end
        FPH_END:
        begin
          link.cs_n <= 1'b1;
          div_r     <= half_done ? 3'h0 : div_r + 3'h1;
          if (half_done)
          begin
            state_r <= FPH_IDLE;
            busy    <= 1'b0;
          end
        end
        default:
          state_r <= FPH_IDLE;
      endcase
    end
  end

  // erase/program tally toward a sector refresh
  logic [15:0] pe_cnt_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pe_cnt_r    <= 16'h0000;
      refresh_due <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r == FPH_IDLE && req && req_pe)
      begin
        if (pe_cnt_r == 16'(fpb_pkg::PE_LIMIT - 1))
        begin
          refresh_due <= 1'b1;
          pe_cnt_r    <= 16'h0000;
        end
        else
          pe_cnt_r <= pe_cnt_r + 16'h0001;
      end
      else if (refresh_ack)
        refresh_due <= 1'b0;
    end
  end

endmodule

// [bench/fpb_link_checker.sv]
// link protocol checker for the serial flash link
`timescale 1ns/1ps
module fpb_link_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe
);
  logic [15:0] rise_r;
  logic        sck_r;
  logic [3:0]  pos;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // status bit position within the two-byte cycle
  assign pos = rise_r[3:0] - 4'h8;

  // sck rises since chip select fell
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rise_r <= 16'h0000;
    else if (cs_n)
      rise_r <= 16'h0000;
    else if (sck && !sck_r)
      rise_r <= rise_r + 16'h0001;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sck_r <= 1'b0;
    else
      sck_r <= sck;
  end

  a_oe_idle_off: assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  a_sck_still_idle: assert property (cs_n |-> !sck)
    else $error("sck moves outside a frame");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("frames too close");
  a_sck_high_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase wrong");
  a_so_hold_rise: assert property ($rose(sck) && so_oe |-> $stable(so))
    else $error("so moved before sampling edge");
  a_oe_after_op: assert property ($rose(so_oe) |-> rise_r == 16'h0008)
    else $error("status output began at wrong bit");
  a_density_bits: assert property (
    $rose(sck) && so_oe && pos >= 4'h2 && pos <= 4'h5
    |-> so == fpb_pkg::DENSITY_CODE[3'd5 - pos[2:0]])
    else $error("capacity code bit wrong");
  a_byte2_zero: assert property (
    $rose(sck) && so_oe && pos inside {4'h9, 4'hA, 4'hB, 4'hC, 4'hF}
    |-> !so)
    else $error("second status byte filler bit set");

  c_status_read: cover property ($rose(so_oe));
  c_long_poll: cover property (so_oe && rise_r > 16'h0030);
  c_frame_end: cover property ($rose(cs_n));
endmodule

// [bench/tb.sv]
// testbench: host and device ends joined over the serial link
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  localparam int RWR_CYC = 40;
  localparam logic [7:0] OPS [6] = '{fpb_pkg::OP_XFR_B1,
    fpb_pkg::OP_XFR_B2, fpb_pkg::OP_CMP_B1, fpb_pkg::OP_CMP_B2,
    fpb_pkg::OP_RWR_B1, fpb_pkg::OP_RWR_B2};
  logic             clk;
  logic             rstn;
  logic             req;
  logic [7:0]       req_op;
  logic [11:0]      req_page;
  logic             bin;
  logic             addr_en;
  logic [2:0]       rd_bytes;
  logic             poll;
  logic             prot;
  logic             susp1;
  logic             susp2;
  logic             mism;
  logic             h_busy;
  logic             rsp_valid;
  logic [7:0]       rsp_byte;
  logic             op_start;
  fpb_pkg::fpb_op_t op_kind;
  logic             op_buf;
  logic [11:0]      op_page;
  logic             op_done;
  logic             d_busy;
  logic             exp_comp;
  int               num_errors;
  int               n_tests;
  int               n_start;
  int               n_done;
  logic [7:0]       rx[$];

  fpb_link_if fpb_link_if_i ();
  fpb_host fpb_host_i (.clk(clk), .rstn(rstn), .ce(1'b1),
    .link(fpb_link_if_i.host), .req(req), .req_op(req_op),
    .req_page(req_page), .req_binary(bin), .req_addr_en(addr_en),
    .req_rd_bytes(rd_bytes), .req_poll(poll), .req_pe(1'b0),
    .refresh_ack(1'b0), .busy(h_busy), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .refresh_due());
  fpb_device #(.REWRITE_CYC(RWR_CYC)) fpb_device_i (.clk(clk),
    .rstn(rstn), .ce(1'b1), .link(fpb_link_if_i.device),
    .binary_page(bin), .protect_en(prot),
    .first_buffer_suspend_flag(susp1),
    .second_buffer_suspend_flag(susp2), .cmp_mismatch(mism),
    .op_start(op_start), .op_kind(op_kind), .op_buf(op_buf),
    .op_page(op_page), .op_done(op_done), .busy(d_busy));
  fpb_link_checker fpb_link_checker_i (.clk(clk), .rstn(rstn),
    .cs_n(fpb_link_if_i.cs_n), .sck(fpb_link_if_i.sck),
    .so(fpb_link_if_i.so), .so_oe(fpb_link_if_i.so_oe));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // collects reply bytes and operation events
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1) rx.push_back(rsp_byte);
    if (op_start === 1'b1) n_start++;
    if (op_done === 1'b1) n_done++;
  end

  function automatic logic [7:0] st1(input logic rdy);
    st1 = {rdy, exp_comp, fpb_pkg::DENSITY_CODE, prot, bin};
  endfunction

  function automatic logic [7:0] st2(input logic rdy);
    st2 = {rdy, 4'h0, susp2, susp1, 1'b0};
  endfunction

  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one host request, returns once the host is idle again
  task automatic host_req(input logic [7:0] op, input logic [11:0] pg,
                          input logic ae, input logic [2:0] n,
                          input logic pl);
    rx.delete();
    req = 1'b1;
    req_op = op;
    req_page = pg;
    addr_en = ae;
    rd_bytes = n;
    poll = pl;
    @(posedge clk);
    #1;
    req = 1'b0;
    for (int k = 0; k < 8000; k++)
    begin
      @(posedge clk);
      #1;
      if (h_busy === 1'b0) return;
    end
    num_errors++;
    print_verdict();
  endtask

  task automatic status(input logic [2:0] n);
    host_req(fpb_pkg::OP_STATUS, 12'h000, 1'b0, n, 1'b0);
  endtask

  // one command from framing to completion, status read on the way
  task automatic do_op(input logic [7:0] op, input logic [11:0] pg,
                       input fpb_pkg::fpb_op_t kind, input logic b,
                       input logic [2:0] n);
    int s0;
    int d0;
    s0 = n_start;
    d0 = n_done;
    host_req(op, pg, 1'b1, n, 1'b0);
    for (int k = 0; k < 20 && n_start == s0; k++)
    begin
      @(posedge clk);
      #1;
    end
    `CHK(n_start - s0, 1)
    `CHK(op_kind, kind)
    `CHK(op_buf, b)
    `CHK(op_page, pg)
    if (kind == fpb_pkg::FPB_XFR || kind == fpb_pkg::FPB_CMP)
    begin
      status(3'd2);
      `CHK(rx[0], st1(1'b0))
      `CHK(rx[1][7], 1'b0)
    end
    if (kind == fpb_pkg::FPB_CMP) exp_comp = mism;
    host_req(fpb_pkg::OP_STATUS, 12'h000, 1'b0, 3'd0, 1'b1);
    `CHK(rx[rx.size() - 1][7], 1'b1)
    `CHK(d_busy, 1'b0)
    `CHK(n_done - d0, 1)
    status(3'd5);
    for (int i = 0; i < 5; i++)
      `CHK(rx[i], i[0] ? st2(1'b1) : st1(1'b1))
  endtask

  // malformed, unknown and suspended-buffer frames start nothing
  task automatic refused();
    int s0;
    s0 = n_start;
    host_req(fpb_pkg::OP_XFR_B1, 12'h010, 1'b0, 3'd0, 1'b0);
    host_req(8'h52, 12'h010, 1'b1, 3'd0, 1'b0);
    host_req(fpb_pkg::OP_XFR_B2, 12'h010, 1'b1, 3'd1, 1'b0);
    susp1 = 1'b1;
    susp2 = 1'b1;
    host_req(fpb_pkg::OP_XFR_B1, 12'h010, 1'b1, 3'd0, 1'b0);
    host_req(fpb_pkg::OP_RWR_B2, 12'h010, 1'b1, 3'd0, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    `CHK(n_start - s0, 0)
    status(3'd2);
    `CHK(rx[1], st2(1'b1))
    susp1 = 1'b0;
    susp2 = 1'b0;
  endtask

  initial
  begin
    logic [11:0] pg;
    rstn = 1'b0;
    req = 1'b0;
    req_op = 8'h00;
    req_page = 12'h000;
    bin = 1'b0;
    addr_en = 1'b0;
    rd_bytes = 3'h0;
    poll = 1'b0;
    prot = 1'b0;
    susp1 = 1'b0;
    susp2 = 1'b0;
    mism = 1'b0;
    exp_comp = fpb_pkg::COMP_RESET;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      pg = i[0] ? 12'hFFF - i[11:0] : 12'h800 + i[11:0];
      bin = i[0];
      prot = ~pg[1];
      mism = pg[1];
      do_op(OPS[i], pg, fpb_pkg::fpb_op_t'(i / 2), i[0], 3'd0);
    end
    do_op(fpb_pkg::OP_RWR_B2, 12'h5A5, fpb_pkg::FPB_RMW, 1'b1, 3'd1);
    refused();
    print_verdict();
  end
endmodule
